// *** core/cies_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
module cies_alu
    import cies_pkg::*;
(
    input wire logic [DATA_W-1:0] opA,
    input wire logic [DATA_W-1:0] accIn,
    input wire logic doXor,
    input wire logic doSwap,
    output logic [DATA_W-1:0] result,
    output logic carryOut,
    output logic halfCarryOut,
    output logic zeroOut
);
    // subtraction as a + ~b + 1 so carries are already inverted borrows
    wire logic [FULL_BIT:0] fullSum = {1'b0, opA} + {1'b0, ~accIn} + 9'h001; // [RULE11]
    wire logic [HALF_BIT:0] halfSum = {1'b0, opA[3:0]} + {1'b0, ~accIn[3:0]} + 5'h01; // [RULE11]
    wire logic [DATA_W-1:0] swapped = {opA[3:0], opA[7:4]}; // [RULE9]
    assign result = doSwap ? swapped : (doXor ? (opA ^ accIn) : fullSum[DATA_W-1:0]);
    assign carryOut = fullSum[FULL_BIT];
    assign halfCarryOut = halfSum[HALF_BIT];
    assign zeroOut = (result == ZERO_BYTE);
endmodule : cies_alu
`default_nettype wire

// *** core/cies_core.sv ***
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cies_core
    import cies_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic instrValid,
    input wire logic [OP_W-1:0] instrWord,
    input wire logic [PC_W-1:0] pushAddr,
    input wire logic pushReq,
    input wire logic [DATA_W-1:0] fileRdData,
    input wire logic wakeReq,
    output logic [ADDR_W-1:0] fileAddr,
    output logic [DATA_W-1:0] fileWrData,
    output logic fileWrEn,
    output logic [DATA_W-1:0] acc,
    output logic carry,
    output logic half_carry,
    output logic zero,
    output logic powerdown_flag_n,
    output logic expiry_flag_n,
    output logic [TMR_W-1:0] supervisor_timer,
    output logic [PRE_W-1:0] timerPrescaler,
    output logic [PC_W-1:0] pc,
    output logic busy,
    output logic oscRun
);
    // file operand is read combinationally from fileRdData with fileAddrW
    logic [DATA_W-1:0] acc_r;
    logic carry_r, halfCarry_r, zero_r, pwrDnN_r, expN_r;
    logic [TMR_W-1:0] tmr_r;
    logic [PRE_W-1:0] pre_r;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] stack_head [STACK_DEPTH];
    logic [SP_W-1:0] sp_r;
    // run flag mirrors sleep so oscRun leaves a flip-flop directly
    logic retBusy_r, asleep_r, wr_r, run_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;

    wire cies_op_type op = instrValid && !retBusy_r && !asleep_r ? cies_decode(instrWord) : OP_NONE; // [RULE4]
    wire logic destFile = instrWord[DEST_BIT];
    wire logic [ADDR_W-1:0] fileAddrW = instrWord[ADDR_W-1:0];
    wire logic isLit = (op == OP_LSUB) || (op == OP_LXOR);
    wire logic [DATA_W-1:0] opA = isLit ? instrWord[DATA_W-1:0] : fileRdData;
    wire logic [DATA_W-1:0] aluRes;
    wire logic aluC, aluHc, aluZ;
    wire logic [SP_W-1:0] spPop = sp_r - 3'h1;
    // read combinationally: a registered stack read would cost the return a third cycle
    wire logic [PC_W-1:0] stackTop = stack_head[spPop];

    cies_alu u_alu (
        .opA(opA),
        .accIn(acc_r),
        .doXor((op == OP_LXOR) || (op == OP_FXOR)),
        .doSwap(op == OP_SWAP),
        .result(aluRes),
        .carryOut(aluC),
        .halfCarryOut(aluHc),
        .zeroOut(aluZ)
    );

    wire logic fileOp = (op == OP_FSUB) || (op == OP_FXOR) || (op == OP_SWAP);
    wire logic writeAcc = isLit || (fileOp && !destFile); // [RULE10]
    wire logic writeFile = fileOp && destFile; // [RULE10]
    wire logic subOp = (op == OP_LSUB) || (op == OP_FSUB);
    wire logic zOp = subOp || (op == OP_LXOR) || (op == OP_FXOR); // [RULE7] [RULE8]

    always_ff @(posedge clk) begin
        if (!nrst) begin
            acc_r <= ZERO_BYTE;
            carry_r <= 1'b0;
            halfCarry_r <= 1'b0;
            zero_r <= 1'b0;
            pwrDnN_r <= 1'b1;
            expN_r <= 1'b1;
            tmr_r <= TMR_CLEARED;
            pre_r <= PRE_CLEARED;
            pc_r <= PC_RESET;
            sp_r <= '0;
            retBusy_r <= 1'b0;
            asleep_r <= 1'b0;
            run_r <= 1'b1;
            wr_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= ZERO_BYTE;
        end else begin
            wr_r <= writeFile;
            addr_r <= fileAddrW; // [RULE6]
            wdata_r <= aluRes;
            retBusy_r <= (op == OP_RET); // [RULE1]
            if (writeAcc) acc_r <= aluRes; // [RULE5] [RULE7]
            if (subOp) begin
                carry_r <= aluC; // [RULE5] [RULE6]
                halfCarry_r <= aluHc;
            end
            if (zOp) zero_r <= aluZ;
            // wake leaves the count where sleep left it
            if (asleep_r && wakeReq) begin
                asleep_r <= 1'b0;
                run_r <= 1'b1;
            end
            if (op == OP_SLEEP) begin
                tmr_r <= TMR_CLEARED; // [RULE2]
                pre_r <= PRE_CLEARED; // [RULE2]
                pwrDnN_r <= 1'b0; // [RULE3]
                expN_r <= 1'b1; // [RULE3]
                asleep_r <= 1'b1; // [RULE4]
                run_r <= 1'b0; // [RULE4]
            end else if (!asleep_r) begin
                {tmr_r, pre_r} <= {tmr_r, pre_r} + 16'h0001;
            end
            if (op == OP_RET) begin
                pc_r <= stack_head[spPop]; // [RULE1]
                sp_r <= spPop;
            end else if (pushReq && !asleep_r) begin
                stack_head[sp_r] <= pushAddr;
                sp_r <= sp_r + 3'h1;
            end else if (op != OP_NONE) begin
                pc_r <= pc_r + 13'h0001;
            end
        end
    end

    assign fileAddr = addr_r;
    assign fileWrData = wdata_r;
    assign fileWrEn = wr_r;
    assign acc = acc_r;
    assign carry = carry_r;
    assign half_carry = halfCarry_r;
    assign zero = zero_r;
    assign powerdown_flag_n = pwrDnN_r;
    assign expiry_flag_n = expN_r;
    assign supervisor_timer = tmr_r;
    assign timerPrescaler = pre_r;
    assign pc = pc_r;
    assign busy = retBusy_r;
    assign oscRun = run_r;

    property p_ret_flags;
        @(posedge clk) disable iff (!nrst) (op == OP_RET) |=> $stable(carry) && $stable(zero) && busy;
    endproperty
    a_ret_flags: assert property (p_ret_flags) else $error("return changed flags"); // [RULE1]
    property p_sleep;
        @(posedge clk) disable iff (!nrst) (op == OP_SLEEP) |=> !powerdown_flag_n && expiry_flag_n
            && supervisor_timer == TMR_CLEARED && !oscRun;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep effects wrong"); // [RULE2] [RULE3]
    property p_lsub;
        @(posedge clk) disable iff (!nrst) (op == OP_LSUB) |=>
            acc == 8'($past(instrWord[7:0]) - $past(acc_r)) && carry == ($past(instrWord[7:0]) >= $past(acc_r));
    endproperty
    a_lsub: assert property (p_lsub) else $error("literal subtract wrong"); // [RULE5]
    property p_lxor;
        @(posedge clk) disable iff (!nrst) (op == OP_LXOR) |=> acc == ($past(acc_r) ^ $past(instrWord[7:0]))
            && $stable(carry);
    endproperty
    a_lxor: assert property (p_lxor) else $error("literal xor wrong"); // [RULE7]
    property p_swap;
        @(posedge clk) disable iff (!nrst) (op == OP_SWAP && destFile) |=> fileWrEn
            && fileWrData == {$past(fileRdData[3:0]), $past(fileRdData[7:4])} && $stable(zero);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong"); // [RULE9]
    property p_dest_acc;
        @(posedge clk) disable iff (!nrst) (fileOp && !destFile) |=> !fileWrEn;
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("destination wrong"); // [RULE10]
    property p_fsub_c;
        @(posedge clk) disable iff (!nrst) (op == OP_FSUB) |=> carry == ($past(fileRdData) >= $past(acc_r))
            && half_carry == ($past(fileRdData[3:0]) >= $past(acc_r[3:0]));
    endproperty
    a_fsub_c: assert property (p_fsub_c) else $error("borrow wrong"); // [RULE11]
    property p_asleep;
        @(posedge clk) disable iff (!nrst) !oscRun && !wakeReq |=> op == OP_NONE;
    endproperty
    a_asleep: assert property (p_asleep) else $error("executed while asleep"); // [RULE4]

    // multi-step behaviours are spelled out as sequences
    sequence s_ret_taken;
        op == OP_RET;
    endsequence

    sequence s_ret_slot;
        busy ##1 !busy;
    endsequence

    sequence s_sleep_taken;
        op == OP_SLEEP;
    endsequence

    sequence s_asleep_state;
        !oscRun && !powerdown_flag_n && expiry_flag_n;
    endsequence

    property p_ret_two;
        @(posedge clk) disable iff (!nrst) s_ret_taken
            |=> s_ret_slot;
    endproperty
    a_ret_two: assert property (p_ret_two) else $error("return not two cycles"); // [RULE1]

    property p_ret_pc;
        @(posedge clk) disable iff (!nrst) s_ret_taken
            |=> pc == $past(stackTop);
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("return target wrong"); // [RULE1]

    property p_ret_sp;
        @(posedge clk) disable iff (!nrst) s_ret_taken
            |=> sp_r == $past(spPop);
    endproperty
    a_ret_sp: assert property (p_ret_sp) else $error("return did not pop"); // [RULE1]

    property p_ret_keep;
        @(posedge clk) disable iff (!nrst) s_ret_taken
            |=> $stable(half_carry) && $stable(acc) && !fileWrEn;
    endproperty
    a_ret_keep: assert property (p_ret_keep) else $error("return changed state"); // [RULE1]

    property p_slot_drop;
        @(posedge clk) disable iff (!nrst) busy
            |=> $stable(acc) && $stable(zero) && $stable(carry) && !fileWrEn;
    endproperty
    a_slot_drop: assert property (p_slot_drop) else $error("busy slot executed"); // [RULE1]

    property p_busy_cause;
        @(posedge clk) disable iff (!nrst) busy
            |-> $past(op == OP_RET);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without return"); // [RULE1]

    property p_sleep_seq;
        @(posedge clk) disable iff (!nrst) s_sleep_taken
            |=> s_asleep_state;
    endproperty
    a_sleep_seq: assert property (p_sleep_seq) else $error("sleep state wrong"); // [RULE3]

    property p_sleep_pre;
        @(posedge clk) disable iff (!nrst) s_sleep_taken
            |=> timerPrescaler == PRE_CLEARED && supervisor_timer == TMR_CLEARED;
    endproperty
    a_sleep_pre: assert property (p_sleep_pre) else $error("prescaler not cleared"); // [RULE2]

    property p_sleep_keep;
        @(posedge clk) disable iff (!nrst) s_sleep_taken
            |=> $stable(carry) && $stable(half_carry) && $stable(zero) && $stable(acc);
    endproperty
    a_sleep_keep: assert property (p_sleep_keep) else $error("sleep touched other flags"); // [RULE3]

    property p_pd_hold;
        @(posedge clk) disable iff (!nrst) !powerdown_flag_n
            |=> !powerdown_flag_n;
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("power-down flag lost"); // [RULE3]

    property p_sleep_hold;
        @(posedge clk) disable iff (!nrst) !oscRun && !wakeReq
            |=> $stable(supervisor_timer) && $stable(timerPrescaler) && $stable(pc);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("state moved while asleep"); // [RULE4]

    property p_sleep_nowr;
        @(posedge clk) disable iff (!nrst) !oscRun
            |=> !fileWrEn && $stable(acc);
    endproperty
    a_sleep_nowr: assert property (p_sleep_nowr) else $error("write while asleep"); // [RULE4]

    property p_wake;
        @(posedge clk) disable iff (!nrst) !oscRun && wakeReq
            |=> oscRun;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not taken"); // [RULE4]

    // flag checks recompute from operands, not from the alu
    property p_lsub_hz;
        @(posedge clk) disable iff (!nrst) (op == OP_LSUB)
            |=> half_carry == ($past(instrWord[3:0]) >= $past(acc_r[3:0])) && zero == (acc == ZERO_BYTE);
    endproperty
    a_lsub_hz: assert property (p_lsub_hz) else $error("literal subtract flags wrong"); // [RULE11]

    property p_lsub_nowr;
        @(posedge clk) disable iff (!nrst) (op == OP_LSUB)
            |=> !fileWrEn;
    endproperty
    a_lsub_nowr: assert property (p_lsub_nowr) else $error("literal subtract wrote file"); // [RULE5]

    property p_fsub_acc;
        @(posedge clk) disable iff (!nrst) (op == OP_FSUB && !destFile)
            |=> acc == 8'($past(fileRdData) - $past(acc_r)) && zero == (acc == ZERO_BYTE);
    endproperty
    a_fsub_acc: assert property (p_fsub_acc) else $error("file subtract wrong"); // [RULE6]

    property p_fsub_file;
        @(posedge clk) disable iff (!nrst) (op == OP_FSUB && destFile)
            |=> fileWrEn && fileWrData == 8'($past(fileRdData) - $past(acc_r)) && $stable(acc);
    endproperty
    a_fsub_file: assert property (p_fsub_file) else $error("file subtract write wrong"); // [RULE10]

    property p_fxor_z;
        @(posedge clk) disable iff (!nrst) (op == OP_FXOR)
            |=> zero == (($past(fileRdData) ^ $past(acc_r)) == ZERO_BYTE) && $stable(carry) && $stable(half_carry);
    endproperty
    a_fxor_z: assert property (p_fxor_z) else $error("file xor flags wrong"); // [RULE8]

    property p_fxor_file;
        @(posedge clk) disable iff (!nrst) (op == OP_FXOR && destFile)
            |=> fileWrEn && fileWrData == ($past(fileRdData) ^ $past(acc_r)) && $stable(acc);
    endproperty
    a_fxor_file: assert property (p_fxor_file) else $error("file xor write wrong"); // [RULE8]

    property p_fxor_acc;
        @(posedge clk) disable iff (!nrst) (op == OP_FXOR && !destFile)
            |=> acc == ($past(fileRdData) ^ $past(acc_r)) && !fileWrEn;
    endproperty
    a_fxor_acc: assert property (p_fxor_acc) else $error("file xor to acc wrong"); // [RULE10]

    property p_lxor_z;
        @(posedge clk) disable iff (!nrst) (op == OP_LXOR)
            |=> zero == (acc == ZERO_BYTE) && $stable(half_carry) && !fileWrEn;
    endproperty
    a_lxor_z: assert property (p_lxor_z) else $error("literal xor zero wrong"); // [RULE7]

    property p_swap_acc;
        @(posedge clk) disable iff (!nrst) (op == OP_SWAP && !destFile)
            |=> acc == {$past(fileRdData[3:0]), $past(fileRdData[7:4])} && $stable(carry) && $stable(half_carry);
    endproperty
    a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong"); // [RULE9]

    property p_wr_addr;
        @(posedge clk) disable iff (!nrst) writeFile
            |=> fileAddr == $past(instrWord[ADDR_W-1:0]);
    endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("write address wrong"); // [RULE6]

    property p_no_wr;
        @(posedge clk) disable iff (!nrst) !writeFile
            |=> !fileWrEn;
    endproperty
    a_no_wr: assert property (p_no_wr) else $error("stray file write"); // [RULE10]
endmodule : cies_core
`default_nettype wire

// *** core/cies_pkg.sv ***
// Contract
// [RULE1] return pops stack, two cycles, flags kept
// [RULE2] power-down clears supervisor timer and prescaler
// [RULE3] power-down clears powerdown_flag_n, sets expiry_flag_n
// [RULE4] power-down halts oscillator, execution stops
// [RULE5] literal minus acc into acc, C DC Z
// [RULE6] file minus acc, C DC Z, address 0..127
// [RULE7] acc xor literal into acc, Z only
// [RULE8] acc xor file to destination, Z only
// [RULE9] nibble exchange of file, no flags
// [RULE10] destination bit 0 acc, 1 file
// [RULE11] carry and half_carry are inverted borrows
package cies_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 13;
    localparam int OP_W = 14;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int TMR_W = 8;
    localparam int PRE_W = 8;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [TMR_W-1:0] TMR_CLEARED = 8'h00;
    localparam logic [PRE_W-1:0] PRE_CLEARED = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam int HALF_BIT = 4;
    localparam int FULL_BIT = 8;
    localparam int DEST_BIT = 7;
    // opcode encodings (whole 14-bit words for return and sleep, upper 6- or 5-bit fields for the rest)
    localparam logic [OP_W-1:0] OPC_RETURN = 14'h0008;
    localparam logic [OP_W-1:0] OPC_SLEEP = 14'h0063;
    localparam logic [5:0] OPC_FILE_SUB = 6'h02;
    localparam logic [5:0] OPC_FILE_XOR = 6'h06;
    localparam logic [5:0] OPC_NIB_SWAP = 6'h0E;
    localparam logic [4:0] OPC_LIT_SUB = 5'h1E;
    localparam logic [5:0] OPC_LIT_XOR = 6'h3A;

    typedef enum logic [2:0] {
        OP_NONE, OP_RET, OP_SLEEP, OP_LSUB, OP_FSUB, OP_LXOR, OP_FXOR, OP_SWAP
    } cies_op_type;

    function automatic cies_op_type cies_decode(input logic [OP_W-1:0] w);
        cies_decode = OP_NONE;
        if (w == OPC_RETURN) cies_decode = OP_RET;
        else if (w == OPC_SLEEP) cies_decode = OP_SLEEP;
        else if (w[13:8] == OPC_FILE_SUB) cies_decode = OP_FSUB;
        else if (w[13:8] == OPC_FILE_XOR) cies_decode = OP_FXOR;
        else if (w[13:8] == OPC_NIB_SWAP) cies_decode = OP_SWAP;
        else if (w[13:9] == OPC_LIT_SUB) cies_decode = OP_LSUB;
        else if (w[13:8] == OPC_LIT_XOR) cies_decode = OP_LXOR;
    endfunction : cies_decode
endpackage : cies_pkg

// *** testbench/cpu_instr_exec_subset_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_instr_exec_subset_tb;
    import cies_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, instrValid = 1'b0, pushReq = 1'b0, wakeReq = 1'b0;
    logic [OP_W-1:0] instrWord = '0;
    logic [PC_W-1:0] pushAddr = '0;
    logic [DATA_W-1:0] fileRdData, fileWrData, acc;
    logic [ADDR_W-1:0] fileAddr;
    logic fileWrEn, carry, half_carry, zero, powerdown_flag_n, expiry_flag_n, busy, oscRun;
    logic [TMR_W-1:0] supervisor_timer;
    logic [PRE_W-1:0] timerPrescaler;
    logic [PC_W-1:0] pc;
    int n_errors = 0;
    int n_compared = 0;
    logic [7:0] mem [128];
    logic [7:0] mAcc = 8'h00;
    logic mC = 1'b0, mH = 1'b0, mZ = 1'b0;
    logic [PC_W-1:0] stk [$];
    // the file model answers combinationally, as the core expects
    assign fileRdData = mem[instrWord[6:0]];
    always #5 clk = ~clk;
    cies_core cies_core_inst (.clk(clk), .nrst(nrst), .instrValid(instrValid), .instrWord(instrWord),
        .pushAddr(pushAddr), .pushReq(pushReq), .fileRdData(fileRdData), .wakeReq(wakeReq),
        .fileAddr(fileAddr), .fileWrData(fileWrData), .fileWrEn(fileWrEn), .acc(acc), .carry(carry),
        .half_carry(half_carry), .zero(zero), .powerdown_flag_n(powerdown_flag_n),
        .expiry_flag_n(expiry_flag_n), .supervisor_timer(supervisor_timer),
        .timerPrescaler(timerPrescaler), .pc(pc), .busy(busy), .oscRun(oscRun));
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task test_done;
        $display("counts: errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    // kind: 0 file sub, 1 literal sub, 2 literal xor, 3 file xor, 4 nibble exchange
    task alu(input int kind, input logic [7:0] k, input logic [6:0] f, input logic d);
        logic [7:0] a, r;
        logic [13:0] w;
        logic wr;
        case (kind)
            0: w = {6'h02, d, f};
            1: w = {6'h3C, k};
            2: w = {6'h3A, k};
            3: w = {6'h06, d, f};
            default: w = {6'h0E, d, f};
        endcase
        a = (kind == 1 || kind == 2) ? k : mem[f];
        r = (kind == 4) ? {a[3:0], a[7:4]} : (kind < 2) ? a - mAcc : a ^ mAcc;
        if (kind < 2) begin
            mC = a >= mAcc;
            mH = a[3:0] >= mAcc[3:0];
        end
        if (kind < 4) mZ = (r == 8'h00);
        wr = d && kind != 1 && kind != 2;
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord <= w;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
        if (wr) mem[f] = r;
        else mAcc = r;
        chk(16'(acc), 16'(mAcc), "acc");
        chk(16'({carry, half_carry, zero}), 16'({mC, mH, mZ}), "flags");
        chk(16'(fileWrEn), 16'(wr), "write enable");
        if (wr) chk(16'({fileAddr, fileWrData}), 16'({f, r}), "write");
    endtask : alu
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
    initial begin
        void'($urandom(6020));
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk(16'({acc, powerdown_flag_n, expiry_flag_n, oscRun, busy}), 16'h000E, "reset");
        alu(1, 8'h00, 7'h00, 1'b0);
        for (int kd = 0; kd < 5; kd++)
            for (int dd = 0; dd < 2; dd++) alu(kd, 8'h0F, 7'h7F, dd[0]);
        repeat (40) alu($urandom % 5, 8'($urandom), 7'($urandom), 1'($urandom));
        $display("test alu done");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            pushReq <= 1'b1;
            pushAddr <= 13'(i * 1111 + 13'h0ABC);
            stk.push_back(13'(i * 1111 + 13'h0ABC));
        end
        @(posedge clk);
        pushReq <= 1'b0;
        repeat (2) begin
            @(posedge clk);
            instrValid <= 1'b1;
            instrWord <= OPC_RETURN;
            @(posedge clk);
            // an instruction in the busy slot must be dropped
            instrWord <= {6'h3A, 8'hFF};
            #1;
            chk(16'({busy, pc}), 16'({1'b1, stk.pop_back()}), "return");
            @(posedge clk);
            instrValid <= 1'b0;
            #1;
            chk(16'({busy, acc, carry, half_carry, zero}), 16'({1'b0, mAcc, mC, mH, mZ}), "busy");
        end
        $display("test return done");
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord <= OPC_SLEEP;
        @(posedge clk);
        instrWord <= {6'h3A, 8'h5A};
        #1;
        chk(16'({supervisor_timer, timerPrescaler}), 16'h0000, "timer");
        chk(16'({powerdown_flag_n, expiry_flag_n, oscRun}), 16'h0002, "sleep flags");
        repeat (3) @(posedge clk);
        instrValid <= 1'b0;
        wakeReq <= 1'b1;
        #1;
        chk(32'({acc, supervisor_timer, oscRun}), 32'({mAcc, 8'h00, 1'b0}), "asleep");
        @(posedge clk);
        wakeReq <= 1'b0;
        #1;
        chk(16'(oscRun), 16'h0001, "wake");
        alu(0, 8'h00, 7'h05, 1'b0);
        $display("test sleep done");
        test_done();
    end
endmodule : cpu_instr_exec_subset_tb
`default_nettype wire
